//--- rtl/smt_pkg.sv
// package for the synchronous master serial transmitter: map, fields, states, carriers
`default_nettype none
package smt_pkg;
    // ----------------------------------------------------------------
    // register byte addresses
    // ----------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] ADDR_TX_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_RX_CTRL = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_BAUD = 5'h08;
    localparam logic [ADDR_W-1:0] ADDR_TX_HOLD = 5'h0c;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h10;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int TXC_MASTER_BIT = 7;
    localparam int TXC_TX_EN_BIT = 5;
    localparam int TXC_SYNC_BIT = 4;
    localparam int TXC_HIGH_SPEED_BIT = 2;
    localparam int TXC_SHIFT_EMPTY_BIT = 1;
    localparam int RXC_PORT_EN_BIT = 7;
    localparam int RXC_SINGLE_RX_BIT = 5;
    localparam int RXC_CONT_RX_BIT = 4;
    localparam int ST_EMPTY_BIT = 0;
    localparam int ST_FULL_BIT = 1;
    localparam int ST_COUNT_LSB = 4;
    localparam int ST_DATA_PIN_BIT = 12;
    localparam int ST_CLOCK_PIN_BIT = 13;
    localparam int ST_BUSY_BIT = 14;

    // ----------------------------------------------------------------
    // widths, timing and answers
    // ----------------------------------------------------------------
    localparam int CHAR_BITS = 8;
    localparam int BAUD_W = 8;
    localparam int BRG_CLOCKS_PER_BIT = 4;
    localparam int HALF_W = 10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [BAUD_W-1:0] BAUD_RESET = 8'h00;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {SMT_IDLE, SMT_LEAD, SMT_TRAIL} smt_state_t;

    typedef struct packed {
        logic master;
        logic tx_en;
        logic sync;
        logic high_speed;
        logic port_en;
        logic single_rx;
        logic cont_rx;
        logic [BAUD_W-1:0] divisor;
    } smt_cfg_t;
endpackage : smt_pkg
`default_nettype wire

//--- rtl/smt_top.sv
// synchronous master serial transmitter with axi4-lite registers and transmit fifo
//
// What this block does
// - data pin is never driven while any receive enable is set; half duplex only
// - only data bits are shifted; no start or stop bit is framed
// - sync mode bit high selects synchronous operation
// - master select bit high makes the port generate the shift clock
// - transmit only while both receive enables are low
// - nothing runs unless the port enable bit is high
// - clock pin driver enabled whenever synchronous master is configured
// - data changes on the leading clock edge, stable at the trailing edge
// - exactly one clock cycle per data bit, no extra pulses
// - master transmit enables both data and clock pin drivers
// - writing the holding register starts a transmission
// - a new character waits while the shift register is busy
// - an empty shift register loads at once and shifting starts right after
// - each data bit holds from one leading edge to the next
// - the shift register is not visible to software
// - bit rate is clock divided by four times divisor plus one
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`default_nettype none

// ----------------------------------------------------------------
// fifo: holding stage between the bus and the shift register
// ----------------------------------------------------------------
module smt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // fill level
    output logic [$clog2(DEPTH):0] count
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W:0] count_q;
    wire logic push;
    wire logic pop;

    // handshakes
    assign in_ready = (count_q != (PTR_W+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_q[rd_ptr_q];
    assign count = count_q;

    // storage
    always_ff @(posedge aclk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // pointers and level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
            rd_ptr_q <= pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
            count_q <= count_q + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};
        end
    end
endmodule : smt_fifo

// ----------------------------------------------------------------
// top: register slave, bit clock generator and shifter
// ----------------------------------------------------------------
module smt_top
    import smt_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // shift clock pin
    input wire logic shift_clock_pin_i,
    output logic shift_clock_pin_o,
    output logic shift_clock_pin_oe,
    // shared data pin
    input wire logic shared_data_pin_i,
    output logic shared_data_pin_o,
    output logic shared_data_pin_oe
);
    localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;
    localparam int BIT_W = $clog2(CHAR_BITS);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ----------------------------------------------------------------
    // configuration and bus state
    // ----------------------------------------------------------------
    smt_cfg_t cfg_q;
    logic [ADDR_W-1:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic have_aw_q;
    logic have_w_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    // shifter state
    smt_state_t state_q;
    logic [CHAR_BITS-1:0] shift_q;
    logic [BIT_W-1:0] bit_cnt_q;
    logic [HALF_W-1:0] half_cnt_q;
    logic clk_q;

    // pin synchronisers
    logic [2:0] dt_sync_q;
    logic [2:0] ck_sync_q;
    logic dt_level_q;
    logic ck_level_q;

    // fifo wires
    wire logic fifo_in_valid;
    wire logic fifo_in_ready;
    wire logic fifo_out_valid;
    wire logic fifo_out_ready;
    wire logic [CHAR_BITS-1:0] fifo_out_data;
    wire logic [CNT_W-1:0] fifo_count;

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    wire logic master_on = cfg_q.port_en & cfg_q.sync & cfg_q.master;
    wire logic rx_req = cfg_q.single_rx | cfg_q.cont_rx;
    wire logic tx_mode = master_on & ~rx_req & cfg_q.tx_en;
    wire logic [HALF_W-1:0] half_len =
        HALF_W'((BRG_CLOCKS_PER_BIT / 2) * (int'(cfg_q.divisor) + 1));
    wire logic tick = (half_cnt_q == half_len - 1'b1);
    wire logic last_bit = (bit_cnt_q == BIT_W'(CHAR_BITS - 1));
    wire logic char_end = (state_q == SMT_TRAIL) & tick & last_bit;
    wire logic load = fifo_out_valid & fifo_out_ready;

    // holding stage drains only into an empty or just finished shift register
    assign fifo_out_ready = tx_mode & ((state_q == SMT_IDLE) | char_end);

    // ----------------------------------------------------------------
    // axi4-lite write path
    // ----------------------------------------------------------------
    wire logic aw_take = s_axi_awvalid & s_axi_awready;
    wire logic w_take = s_axi_wvalid & s_axi_wready;
    wire logic to_hold = (waddr_q == ADDR_TX_HOLD);
    wire logic w_mapped = (waddr_q == ADDR_TX_CTRL) | (waddr_q == ADDR_RX_CTRL) |
        (waddr_q == ADDR_BAUD) | to_hold | (waddr_q == ADDR_STATUS);
    wire logic commit = have_aw_q & have_w_q & ~bvalid_q & (~to_hold | fifo_in_ready);
    wire logic lane0 = commit & wstrb_q[0];

    assign s_axi_awready = ~have_aw_q & ~bvalid_q;
    assign s_axi_wready = ~have_w_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign fifo_in_valid = lane0 & to_hold;

    // write capture and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            waddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            have_aw_q <= 1'b0;
            have_w_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                waddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            have_aw_q <= commit ? 1'b0 : (have_aw_q | aw_take);
            have_w_q <= commit ? 1'b0 : (have_w_q | w_take);
            if (commit) begin
                bvalid_q <= 1'b1;
                bresp_q <= w_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // configuration registers, byte lane 0 only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= '{default: 1'b0, divisor: BAUD_RESET};
        end else if (lane0) begin
            if (waddr_q == ADDR_TX_CTRL) begin
                cfg_q.master <= wdata_q[TXC_MASTER_BIT];
                cfg_q.tx_en <= wdata_q[TXC_TX_EN_BIT];
                cfg_q.sync <= wdata_q[TXC_SYNC_BIT];
                cfg_q.high_speed <= wdata_q[TXC_HIGH_SPEED_BIT];
            end
            if (waddr_q == ADDR_RX_CTRL) begin
                cfg_q.port_en <= wdata_q[RXC_PORT_EN_BIT];
                cfg_q.single_rx <= wdata_q[RXC_SINGLE_RX_BIT];
                cfg_q.cont_rx <= wdata_q[RXC_CONT_RX_BIT];
            end
            if (waddr_q == ADDR_BAUD) begin
                cfg_q.divisor <= wdata_q[BAUD_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read path
    // ----------------------------------------------------------------
    wire logic ar_take = s_axi_arvalid & s_axi_arready;
    wire logic busy = (state_q != SMT_IDLE);
    wire logic [31:0] rd_tx_ctrl = 32'(cfg_q.master) << TXC_MASTER_BIT |
        32'(cfg_q.tx_en) << TXC_TX_EN_BIT | 32'(cfg_q.sync) << TXC_SYNC_BIT |
        32'(cfg_q.high_speed) << TXC_HIGH_SPEED_BIT | 32'(!busy) << TXC_SHIFT_EMPTY_BIT;
    wire logic [31:0] rd_rx_ctrl = 32'(cfg_q.port_en) << RXC_PORT_EN_BIT |
        32'(cfg_q.single_rx) << RXC_SINGLE_RX_BIT | 32'(cfg_q.cont_rx) << RXC_CONT_RX_BIT;
    wire logic [31:0] rd_status = 32'(fifo_count == '0) << ST_EMPTY_BIT |
        32'(!fifo_in_ready) << ST_FULL_BIT | 32'(fifo_count) << ST_COUNT_LSB |
        32'(dt_level_q) << ST_DATA_PIN_BIT | 32'(ck_level_q) << ST_CLOCK_PIN_BIT |
        32'(busy) << ST_BUSY_BIT;
    // the holding register is write only and the shift register has no address
    wire logic [31:0] rd_mux = (s_axi_araddr == ADDR_TX_CTRL) ? rd_tx_ctrl :
        (s_axi_araddr == ADDR_RX_CTRL) ? rd_rx_ctrl :
        (s_axi_araddr == ADDR_BAUD) ? 32'(cfg_q.divisor) :
        (s_axi_araddr == ADDR_STATUS) ? rd_status : 32'h0000_0000;
    wire logic r_mapped = (s_axi_araddr == ADDR_TX_CTRL) | (s_axi_araddr == ADDR_RX_CTRL) |
        (s_axi_araddr == ADDR_BAUD) | (s_axi_araddr == ADDR_TX_HOLD) |
        (s_axi_araddr == ADDR_STATUS);

    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // read answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= r_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // pin synchronisers: a level counts once the last two stages agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dt_sync_q <= '0;
            ck_sync_q <= '0;
            dt_level_q <= 1'b0;
            ck_level_q <= 1'b0;
        end else begin
            dt_sync_q <= {dt_sync_q[1:0], shared_data_pin_i};
            ck_sync_q <= {ck_sync_q[1:0], shift_clock_pin_i};
            dt_level_q <= (dt_sync_q[2] == dt_sync_q[1]) ? dt_sync_q[2] : dt_level_q;
            ck_level_q <= (ck_sync_q[2] == ck_sync_q[1]) ? ck_sync_q[2] : ck_level_q;
        end
    end

    // ----------------------------------------------------------------
    // holding fifo
    // ----------------------------------------------------------------
    smt_fifo #(
        .WIDTH(CHAR_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_hold (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(wdata_q[CHAR_BITS-1:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );

    // ----------------------------------------------------------------
    // bit clock and shifter
    // ----------------------------------------------------------------
    // a character is data bits only, lsb first, clock high in the first half
    always_ff @(posedge aclk) begin
        if (!aresetn || !tx_mode) begin
            state_q <= SMT_IDLE;
            clk_q <= 1'b0;
            half_cnt_q <= '0;
            bit_cnt_q <= '0;
            shift_q <= '0;
        end else begin
            half_cnt_q <= (tick || state_q == SMT_IDLE) ? '0 : half_cnt_q + 1'b1;
            case (state_q)
                SMT_IDLE: begin
                    if (load) begin
                        state_q <= SMT_LEAD;
                        clk_q <= 1'b1;
                        shift_q <= fifo_out_data;
                        bit_cnt_q <= '0;
                    end
                end
                SMT_LEAD: begin
                    if (tick) begin
                        state_q <= SMT_TRAIL;
                        clk_q <= 1'b0;
                    end
                end
                SMT_TRAIL: begin
                    if (tick && !last_bit) begin
                        state_q <= SMT_LEAD;
                        clk_q <= 1'b1;
                        shift_q <= shift_q >> 1;
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                    end else if (char_end && load) begin
                        state_q <= SMT_LEAD;
                        clk_q <= 1'b1;
                        shift_q <= fifo_out_data;
                        bit_cnt_q <= '0;
                    end else if (char_end) begin
                        state_q <= SMT_IDLE;
                    end
                end
                default: begin
                    state_q <= SMT_IDLE;
                end
            endcase
        end
    end

    // pin drive; receive itself is not built, so receive setups only release data
    assign shift_clock_pin_o = clk_q;
    assign shift_clock_pin_oe = master_on;
    assign shared_data_pin_o = shift_q[0];
    assign shared_data_pin_oe = tx_mode;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [HALF_W:0] hi_cnt_q;
    logic [BIT_W+1:0] rise_cnt_q;
    logic clk_d1_q;

    // helper: high-phase length and leading edges per character
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hi_cnt_q <= '0;
            rise_cnt_q <= '0;
            clk_d1_q <= 1'b0;
        end else begin
            clk_d1_q <= clk_q;
            hi_cnt_q <= clk_q ? hi_cnt_q + 1'b1 : '0;
            rise_cnt_q <= load ? '0 : rise_cnt_q + (BIT_W+2)'(clk_q & ~clk_d1_q);
        end
    end

    property p_idle_clock;
        state_q == SMT_IDLE |-> !clk_q;
    endproperty
    a_idle_clock: assert property (p_idle_clock) else $error("clock not idle low");

    property p_half_duplex;
        rx_req |-> !shared_data_pin_oe ##1 state_q == SMT_IDLE;
    endproperty
    a_half_duplex: assert property (p_half_duplex) else $error("driving while rx");

    property p_bit_hold;
        clk_q && !tick |=> $stable(shared_data_pin_o) || !tx_mode;
    endproperty
    a_bit_hold: assert property (p_bit_hold) else $error("data moved mid bit");

    property p_half_period;
        clk_d1_q && !clk_q && $past(tx_mode) && tx_mode |->
            hi_cnt_q == {1'b0, $past(half_len)};
    endproperty
    a_half_period: assert property (p_half_period) else $error("high phase length");

    property p_bits_per_char;
        rise_cnt_q <= (BIT_W+2)'(CHAR_BITS);
    endproperty
    a_bits_per_char: assert property (p_bits_per_char) else $error("extra clocks");

    property p_load_at_once;
        state_q == SMT_IDLE && fifo_out_valid && tx_mode |=> state_q == SMT_LEAD && clk_q;
    endproperty
    a_load_at_once: assert property (p_load_at_once) else $error("load delayed");

    property p_wait_busy;
        state_q == SMT_LEAD |=> fifo_count >= $past(fifo_count);
    endproperty
    a_wait_busy: assert property (p_wait_busy) else $error("overwrote shifter");

    property p_drivers;
        state_q != SMT_IDLE |-> $past(shift_clock_pin_oe && shared_data_pin_oe);
    endproperty
    a_drivers: assert property (p_drivers) else $error("driver off in tx");

    property p_disable;
        !cfg_q.port_en |-> !shift_clock_pin_oe && !shared_data_pin_oe ##1 state_q == SMT_IDLE;
    endproperty
    a_disable: assert property (p_disable) else $error("runs while disabled");

    property p_write_starts;
        commit && wstrb_q[0] && to_hold && tx_mode && state_q == SMT_IDLE &&
            fifo_count == '0 |=> ##1 state_q == SMT_LEAD;
    endproperty
    a_write_starts: assert property (p_write_starts) else $error("write did not start");
endmodule : smt_top
`default_nettype wire

//--- tb/smt_slave_model.sv
// far-side slave model: shifts the shared data line in on the master clock
`default_nettype none
module smt_slave_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link wires
    input wire logic sck,
    input wire logic sdat,
    // what was seen
    output var logic [7:0] rx_byte,
    output var int n_char,
    output var int n_rise,
    output var int period,
    output var int n_glitch
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sck_q, dat_q, act_q;
    logic [7:0] sh_q;
    int nb_q, cnt_q;
    // no clock of its own: every shift follows an edge of the supplied clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_q <= 1'b0;
            dat_q <= 1'b0;
            act_q <= 1'b0;
            sh_q <= 8'h00;
            rx_byte <= 8'h00;
            n_char <= 0;
            n_rise <= 0;
            period <= 0;
            n_glitch <= 0;
            nb_q <= 0;
            cnt_q <= 0;
        end else begin
            sck_q <= sck;
            dat_q <= sdat;
            cnt_q <= cnt_q + 1;
            if (sck && !sck_q) begin
                n_rise <= n_rise + 1;
                period <= cnt_q + 1; // cycles between leading edges
                cnt_q <= 0;
                act_q <= 1'b1;
            end else if (act_q && sdat !== dat_q) begin
                n_glitch <= n_glitch + 1;
            end
            if (!sck && sck_q) begin
                sh_q <= {sdat, sh_q[7:1]};
                nb_q <= (nb_q == 7) ? 0 : nb_q + 1;
                act_q <= (nb_q != 7);
                if (nb_q == 7) begin
                    rx_byte <= {sdat, sh_q[7:1]};
                    n_char <= n_char + 1;
                end
            end
        end
    end
endmodule : smt_slave_model
`default_nettype wire

//--- tb/tb_smt_top.sv
// testbench for the synchronous master serial transmitter
`default_nettype none
module tb_smt_top import smt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, awv, wv, bry, arv, rry, awr, wr_r, bv, arr, rv;
    logic ck_o, ck_oe, sd_o, sd_oe;
    logic [ADDR_W-1:0] awa, ara;
    logic [31:0] wd, rd_d;
    logic [3:0] ws;
    logic [1:0] br, rr, rsp;
    logic [7:0] rx_byte;
    wire logic ck_w, sd_w;
    int err_total, n_tests, cyc, seen, r0, n_char, n_rise, period, n_glitch;
    assign ck_w = ck_oe ? ck_o : 1'b0; // pull-down on the clock line
    assign sd_w = sd_oe ? sd_o : 1'b1; // pull-up on the data line
    smt_top #(.FIFO_DEPTH(16)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .shift_clock_pin_i(ck_w), .shift_clock_pin_o(ck_o),
        .shift_clock_pin_oe(ck_oe), .shared_data_pin_i(sd_w), .shared_data_pin_o(sd_o),
        .shared_data_pin_oe(sd_oe));
    smt_slave_model slave (.aclk(aclk), .aresetn(aresetn), .sck(ck_w), .sdat(sd_w),
        .rx_byte(rx_byte), .n_char(n_char), .n_rise(n_rise), .period(period),
        .n_glitch(n_glitch));
    // ----------------------------------------------------------------
    // bus tasks and comparisons
    // ----------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awa <= a;
        wd <= d;
        ws <= 4'hf;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        // each valid drops at the edge where its ready is seen; the wait ends when bvalid is seen, or else at the hang guard
        do begin
            @(posedge aclk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr_r === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1);
        rsp = br;
        bry <= 1'b0;
        chk({30'h0, rsp}, {30'h0, er});
    endtask : wr
    task rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] d;
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1);
        d = rd_d;
        rsp = rr;
        rry <= 1'b0;
        chk(d & m, e);
    endtask : rd
    task ec(input logic [7:0] e);
        while (n_char <= seen) @(posedge aclk);
        seen++;
        chk({24'h0, rx_byte}, {24'h0, e});
    endtask : ec
    task test_done;
        $display("errors %0d checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    // clock and hang guard
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    // main sequence
    initial begin
        {aresetn, awv, wv, bry, arv, rry, awa, ara, wd, ws} = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_TX_CTRL, 32'h2, 32'hff);
        rd(ADDR_STATUS, 32'h1, 32'h41f3);
        rd(5'h14, 32'h0, 32'hffffffff);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        wr(5'h14, 32'hff, RESP_SLVERR);
        chk({30'h0, ck_oe, sd_oe}, 32'h0);
        wr(ADDR_BAUD, 32'h1, RESP_OKAY);
        wr(ADDR_TX_CTRL, 32'hb0, RESP_OKAY);
        wr(ADDR_RX_CTRL, 32'h80, RESP_OKAY);
        rd(ADDR_BAUD, 32'h1, 32'hff);
        chk({30'h0, ck_oe, sd_oe}, 32'h3);
        r0 = n_rise;
        wr(ADDR_TX_HOLD, 32'ha5, RESP_OKAY);
        wr(ADDR_TX_HOLD, 32'h3c, RESP_OKAY);
        ec(8'ha5);
        ec(8'h3c);
        chk(32'(period), 32'h8);
        repeat (40) @(posedge aclk);
        chk(32'(n_rise - r0), 32'd16);
        chk({31'h0, ck_o}, 32'h0);
        rd(ADDR_TX_CTRL, 32'hb2, 32'hff);
        rd(ADDR_TX_HOLD, 32'h0, 32'hffffffff);
        wr(ADDR_RX_CTRL, 32'ha0, RESP_OKAY);
        chk({30'h0, ck_oe, sd_oe}, 32'h2);
        r0 = n_rise;
        wr(ADDR_TX_HOLD, 32'h55, RESP_OKAY);
        repeat (100) @(posedge aclk);
        chk(32'(n_rise - r0), 32'h0);
        rd(ADDR_STATUS, 32'h1010, 32'h71f3);
        wr(ADDR_RX_CTRL, 32'h90, RESP_OKAY);
        chk({30'h0, ck_oe, sd_oe}, 32'h2);
        wr(ADDR_TX_CTRL, 32'ha0, RESP_OKAY);
        chk({31'h0, ck_oe}, 32'h0);
        wr(ADDR_TX_CTRL, 32'h30, RESP_OKAY);
        chk({31'h0, ck_oe}, 32'h0);
        wr(ADDR_TX_CTRL, 32'hb4, RESP_OKAY);
        wr(ADDR_RX_CTRL, 32'h0, RESP_OKAY);
        chk({30'h0, ck_oe, sd_oe}, 32'h0);
        for (int i = 1; i < 16; i++) wr(ADDR_TX_HOLD, 32'h10 + i, RESP_OKAY);
        rd(ADDR_STATUS, 32'h102, 32'h41f3);
        wr(ADDR_BAUD, 32'h0, RESP_OKAY);
        wr(ADDR_RX_CTRL, 32'h80, RESP_OKAY);
        ec(8'h55);
        for (int i = 1; i < 16; i++) ec(8'h10 + 8'(i));
        chk(32'(period), 32'h4);
        chk(32'(n_glitch), 32'h0);
        test_done();
    end
endmodule : tb_smt_top
`default_nettype wire
